// ===== verilog/sbs_pkg.sv
// package: constants and types shared by both ends of the burst/sleep memory link
package sbs_pkg;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned MEM_DEPTH       = 256;
  localparam int unsigned BURST_LEN       = 4;
  localparam int unsigned SLEEP_ENTRY_CYC = 2;
  localparam int unsigned SLEEP_RECOV_CYC = 2;
  localparam logic [1:0]  CNT_RST         = 2'h0;
  localparam logic [1:0]  SLP_CNT_RST     = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  // controller register map (word index on the software port)
  localparam logic [3:0]  REG_CMD         = 4'h0;
  localparam logic [3:0]  REG_ADDR        = 4'h1;
  localparam logic [3:0]  REG_WDATA       = 4'h2;
  localparam logic [3:0]  REG_RDATA       = 4'h3;
  localparam logic [3:0]  REG_CTRL        = 4'h4;
  localparam logic [3:0]  REG_STAT        = 4'h5;
  // command register field positions
  localparam int unsigned CMD_RD_BIT      = 0;
  localparam int unsigned CMD_WR_BIT      = 1;
  localparam int unsigned CMD_ADV_BIT     = 2;
  // control register field positions
  localparam int unsigned CTRL_SLEEP_BIT  = 0;
  localparam int unsigned CTRL_FT_N_BIT   = 1;
  localparam int unsigned CTRL_LIN_N_BIT  = 2;
  localparam logic [2:0]  CTRL_RST        = 3'h6;
  localparam logic [1:0]  RD_LAT_PIPE     = 2'h2;
  localparam logic [1:0]  RD_LAT_FLOW     = 2'h1;

  typedef enum logic [1:0] {
    SBS_AWAKE   = 2'b00,
    SBS_ENTER   = 2'b01,
    SBS_ASLEEP  = 2'b11,
    SBS_RECOVER = 2'b10
  } sbs_power_t;

  // burst address step: linear adds, interleaved xors
  function automatic logic [1:0] sbs_burst_addr(input logic [1:0] base_i,
                                                input logic [1:0] cnt_i,
                                                input logic       inter_i);
    sbs_burst_addr = inter_i ? (base_i ^ cnt_i) : 2'(base_i + cnt_i);
  endfunction
endpackage

// ===== verilog/sbs_link_if.sv
// interface: pins between memory controller and memory device
`timescale 1ns/1ns
interface sbs_link_if
  import sbs_pkg::*;
();
  logic              sleep_request;
  logic              flow_through_select_n;
  logic              linear_order_select_n;
  logic              burst_advance;
  logic              cmd_read;
  logic              cmd_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_ctl_o;
  logic              dq_ctl_oe;
  logic [DATA_W-1:0] dq_mem_o;
  logic              dq_mem_oe;
  logic [DATA_W-1:0] dq;

  assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);

  modport ctl (output sleep_request, flow_through_select_n, linear_order_select_n,
               burst_advance, cmd_read, cmd_write, addr, dq_ctl_o, dq_ctl_oe,
               input dq);
  modport mem (input sleep_request, flow_through_select_n, linear_order_select_n,
               burst_advance, cmd_read, cmd_write, addr, dq_ctl_o, dq_ctl_oe,
               output dq_mem_o, dq_mem_oe);
endinterface

// ===== verilog/sbs_sleep_sync.sv
// sleep request synchroniser and entry/recovery sequencer
`timescale 1ns/1ns
module sbs_sleep_sync
  import sbs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sleep_request_i,
  output logic      asleep_o,
  output logic      recovering_o
);
  logic       meta_r;
  logic       sync_r;
  logic [1:0] cnt_r;
  sbs_power_t state_r;

  // two-flop synchroniser; request is not timed to the clock
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= sleep_request_i;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= SBS_AWAKE;
      cnt_r   <= SLP_CNT_RST;
    end else begin
      case (state_r)
        // the edge into enter is already the first interval cycle, so count starts one short
        SBS_AWAKE: begin
          if (sync_r) begin
            state_r <= SBS_ENTER;
            cnt_r   <= 2'(SLEEP_ENTRY_CYC - 2);
          end
        end
        SBS_ENTER: begin
          if (cnt_r == 2'h0) begin
            state_r <= SBS_ASLEEP;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        SBS_ASLEEP: begin
          if (!sync_r) begin
            state_r <= SBS_RECOVER;
            cnt_r   <= 2'(SLEEP_RECOV_CYC - 2);
          end
        end
        SBS_RECOVER: begin
          if (sync_r) begin
            state_r <= SBS_ENTER;
            cnt_r   <= 2'(SLEEP_ENTRY_CYC - 2);
          end else if (cnt_r == 2'h0) begin
            state_r <= SBS_AWAKE;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        default: state_r <= SBS_AWAKE;
      endcase
    end
  end

  assign asleep_o     = (state_r == SBS_ASLEEP);
  assign recovering_o = (state_r == SBS_RECOVER);
endmodule

// ===== verilog/sbs_mem_dev.sv
// memory device end: burst sequencer, storage, sleep and output timing
`timescale 1ns/1ns
module sbs_mem_dev
  import sbs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  sbs_link_if.mem   link,
  output logic      asleep_o
);
  logic [DATA_W-1:0] mem_r [MEM_DEPTH];
  logic [ADDR_W-1:0] base_r;
  logic [1:0]        cnt_r;
  logic              burst_rd_r;
  logic              burst_wr_r;
  logic              asleep;
  logic              recovering;
  logic              inter;
  logic              pipe;
  logic              rd_go;
  logic              wr_go;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] flow_q_r;
  logic              flow_v_r;
  logic [DATA_W-1:0] pipe_q_r;
  logic              pipe_v_r;

  sbs_sleep_sync u_sleep (
    .clk_i           (clk_i),
    .sys_rst_i       (sys_rst_i),
    .sleep_request_i (link.sleep_request),
    .asleep_o        (asleep),
    .recovering_o    (recovering)
  );

  assign asleep_o = asleep;
  assign inter    = link.linear_order_select_n;
  assign pipe     = link.flow_through_select_n;

  // burst step chooses the low address bits, upper bits fixed by load
  always_comb begin
    if (link.burst_advance) begin
      acc_addr = {base_r[ADDR_W-1:2], sbs_burst_addr(base_r[1:0], 2'(cnt_r + 2'h1), inter)};
    end else begin
      acc_addr = link.addr;
    end
  end

  // advance only continues a burst that was opened by a load
  assign rd_go = !asleep && (link.burst_advance ? burst_rd_r : link.cmd_read);
  assign wr_go = !asleep && (link.burst_advance ? burst_wr_r : link.cmd_write);

  // counter and burst kind freeze while asleep, so nothing is lost
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      base_r     <= '0;
      cnt_r      <= CNT_RST;
      burst_rd_r <= 1'b0;
      burst_wr_r <= 1'b0;
    end else if (!asleep) begin
      // a deselect holds the burst, so a later advance can still continue it
      if (!link.burst_advance && (link.cmd_read || link.cmd_write)) begin
        base_r     <= link.addr;
        cnt_r      <= CNT_RST;
        burst_rd_r <= link.cmd_read;
        burst_wr_r <= link.cmd_write;
      end else if (link.burst_advance) begin
        cnt_r <= 2'(cnt_r + 2'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_go) begin
      mem_r[acc_addr] <= link.dq_ctl_o;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flow_q_r <= DATA_RST;
      flow_v_r <= 1'b0;
    end else begin
      flow_v_r <= rd_go;
      if (rd_go) begin
        flow_q_r <= mem_r[acc_addr];
      end
    end
  end

  // pipelined mode adds one output register stage
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pipe_q_r <= DATA_RST;
      pipe_v_r <= 1'b0;
    end else begin
      pipe_v_r <= flow_v_r && !asleep;
      pipe_q_r <= flow_q_r;
    end
  end

  always_comb begin
    link.dq_mem_o  = pipe ? pipe_q_r : flow_q_r;
    link.dq_mem_oe = !asleep && (pipe ? pipe_v_r : flow_v_r);
  end

  logic unused_rec;
  assign unused_rec = recovering;
endmodule

// ===== verilog/sbs_mem_ctl.sv
// memory controller end: software port, command issue, sleep and straps
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module sbs_mem_ctl
  import sbs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [3:0]        addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  sbs_link_if.ctl                link
);
  logic [2:0]        ctrl_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic              cmd_rd_r;
  logic              cmd_wr_r;
  logic              adv_r;
  logic              drv_r;
  logic [1:0]        busy_r;
  logic [1:0]        wake_r;
  logic              rvalid_r;
  logic              rd_kind_r;
  logic              idle;
  logic              cmd_wr_hit;
  logic              wr_ok;
  logic [1:0]        lat;

  assign cmd_wr_hit = wr_i && (addr_i == REG_CMD);
  // a command already on the pins counts as pending before busy_r loads
  assign idle       = (busy_r == 2'h0) && !cmd_rd_r && !cmd_wr_r;
  assign lat        = ctrl_r[CTRL_FT_N_BIT] ? RD_LAT_PIPE : RD_LAT_FLOW;
  // writes refused while asleep or recovering
  assign wr_ok      = !ctrl_r[CTRL_SLEEP_BIT] && (wake_r == 2'h0);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r  <= CTRL_RST;
      addr_r  <= '0;
      wdata_r <= DATA_RST;
    end else if (wr_i) begin
      case (addr_i)
        REG_ADDR:  addr_r  <= wdata_i[ADDR_W-1:0];
        REG_WDATA: wdata_r <= wdata_i;
        REG_CTRL: begin
          // sleep only once nothing is in flight
          ctrl_r[CTRL_SLEEP_BIT] <= wdata_i[CTRL_SLEEP_BIT] && idle;
          ctrl_r[CTRL_FT_N_BIT]  <= wdata_i[CTRL_FT_N_BIT];
          ctrl_r[CTRL_LIN_N_BIT] <= wdata_i[CTRL_LIN_N_BIT];
        end
        default: ;
      endcase
    end
  end

  // one command cycle per write of the command register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_rd_r <= 1'b0;
      cmd_wr_r <= 1'b0;
      adv_r    <= 1'b0;
      drv_r    <= 1'b0;
    end else begin
      cmd_rd_r <= cmd_wr_hit && !ctrl_r[CTRL_SLEEP_BIT] && wdata_i[CMD_RD_BIT];
      cmd_wr_r <= cmd_wr_hit && wr_ok && wdata_i[CMD_WR_BIT];
      adv_r    <= cmd_wr_hit && wdata_i[CMD_ADV_BIT];
      drv_r    <= cmd_wr_hit && wr_ok && wdata_i[CMD_WR_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r    <= 2'h0;
      wake_r    <= 2'h0;
      rd_kind_r <= 1'b0;
    end else begin
      if (cmd_rd_r || cmd_wr_r) begin
        busy_r    <= 2'(lat + 2'h1);
        rd_kind_r <= cmd_rd_r;
      end else if (busy_r != 2'h0) begin
        busy_r <= busy_r - 2'h1;
      end
      // the device resyncs the drop, so allow its two flops plus recovery
      if (wr_i && addr_i == REG_CTRL && ctrl_r[CTRL_SLEEP_BIT] && !wdata_i[CTRL_SLEEP_BIT]) begin
        wake_r <= 2'(SLEEP_RECOV_CYC + 1);
      end else if (wake_r != 2'h0) begin
        wake_r <= wake_r - 2'h1;
      end
    end
  end

  // read data captured when the device drives the bus
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_r  <= DATA_RST;
      rvalid_r <= 1'b0;
    end else begin
      // busy_r passes 2 exactly in the beat cycle, in either output timing
      if (busy_r == 2'h2 && rd_kind_r) begin
        rdata_r <= link.dq;
      end
      if (cmd_rd_r) begin
        rvalid_r <= 1'b0;
      end else if (busy_r == 2'h1) begin
        rvalid_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= DATA_RST;
    end else if (rd_i) begin
      case (addr_i)
        REG_ADDR:  rdata_o <= DATA_W'(addr_r);
        REG_WDATA: rdata_o <= wdata_r;
        REG_RDATA: rdata_o <= rdata_r;
        REG_CTRL:  rdata_o <= DATA_W'(ctrl_r);
        REG_STAT:  rdata_o <= DATA_W'({wake_r != 2'h0, busy_r != 2'h0, rvalid_r});
        default:   rdata_o <= DATA_RST;
      endcase
    end else begin
      rdata_o <= DATA_RST;
    end
  end

  always_comb begin
    link.sleep_request         = ctrl_r[CTRL_SLEEP_BIT];
    link.flow_through_select_n = ctrl_r[CTRL_FT_N_BIT];
    link.linear_order_select_n = ctrl_r[CTRL_LIN_N_BIT];
    link.burst_advance         = adv_r;
    link.cmd_read              = cmd_rd_r;
    link.cmd_write             = cmd_wr_r;
    link.addr                  = addr_r;
    link.dq_ctl_o              = wdata_r;
    link.dq_ctl_oe             = drv_r;
  end
endmodule

// ===== dv/sbs_link_asserts.sv
// checker: sleep, release and read timing on the controller/device link
`timescale 1ns/1ns
module sbs_link_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sleep_request,
  input wire logic flow_through_select_n,
  input wire logic burst_advance,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic dq_mem_oe,
  input wire logic asleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // two synchroniser flops plus the two-cycle interval, seen one edge later
  sequence s_sleep_held;
    sleep_request [*5];
  endsequence
  sequence s_wake_held;
    !sleep_request [*5];
  endsequence
  AST_ENTER_NOT_EARLY: assert property ($rose(sleep_request) |-> !asleep_o [*2])
    else $error("sleep entered before request was synchronised");
  AST_ENTER_BOUND: assert property (s_sleep_held |-> asleep_o)
    else $error("sleep not entered while request held");
  AST_STAY_WHILE_LOW: assert property (s_wake_held |-> !asleep_o)
    else $error("asleep without a request");
  AST_WAKE_NOT_EARLY: assert property ($fell(sleep_request) && asleep_o |-> asleep_o [*2])
    else $error("woke before the wake-up interval");
  AST_ASLEEP_RELEASED: assert property (asleep_o |-> !dq_mem_oe)
    else $error("data bus driven while asleep");
  AST_NO_WRITE_RECOVER: assert property ($fell(sleep_request) |-> !cmd_write [*4])
    else $error("write issued during recovery");
  AST_DRAIN_FIRST: assert property ((cmd_read || cmd_write) |=> (!$rose(sleep_request)) [*2])
    else $error("sleep raised with an operation pending");
  AST_READ_PIPE: assert property (cmd_read && !burst_advance && flow_through_select_n
                                  && !asleep_o |-> ##2 dq_mem_oe)
    else $error("pipelined read data not two cycles after command");
  AST_READ_FLOW: assert property (cmd_read && !burst_advance && !flow_through_select_n
                                  && !asleep_o |=> dq_mem_oe)
    else $error("flow-through read data not one cycle after command");
  AST_OE_CAUSE: assert property (dq_mem_oe |-> $past(cmd_read, 1) || $past(cmd_read, 2))
    else $error("device drove data with no read");
endmodule

// ===== dv/sbs_test.sv
// testbench: controller and device joined, driven over the software port
`timescale 1ns/1ns
module sbs_test
  import sbs_pkg::*;
();
  logic              clk_i;
  logic              sys_rst_i;
  logic [3:0]        addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic              asleep;
  logic [DATA_W-1:0] got;
  logic [1:0]        e;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cyc       = 0;

  sbs_link_if link ();
  sbs_mem_ctl i_sbs_mem_ctl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
  sbs_mem_dev i_sbs_mem_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .asleep_o(asleep));
  sbs_link_asserts i_sbs_link_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sleep_request(link.sleep_request), .flow_through_select_n(link.flow_through_select_n),
    .burst_advance(link.burst_advance), .cmd_read(link.cmd_read),
    .cmd_write(link.cmd_write), .dq_mem_oe(link.dq_mem_oe), .asleep_o(asleep));

  task automatic chk(input string n, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] s);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  // one strobe cycle; read data is taken in the cycle after the strobe
  task automatic bus(input logic [3:0] a, input logic [DATA_W-1:0] d, input logic w);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  // four cycles covers the slower pipelined answer
  task automatic mem_cmd(input logic [DATA_W-1:0] c);
    bus(REG_CMD, c, 1'b1);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic mem_rd(input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] x, input string n);
    mem_cmd(c);
    bus(REG_RDATA, 16'h0000, 1'b0);
    chk(n, x, got);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    addr_i    = 4'h0;
    wdata_i   = 16'h0000;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(REG_CTRL, 16'h0000, 1'b0);
    chk("ctrl_reset", {13'h0000, CTRL_RST}, got);
    chk("ft_pin_reset", 16'h0001, {15'h0000, link.flow_through_select_n});
    chk("sleep_low", 16'h0000, {15'h0000, link.sleep_request});
    bus(4'hF, 16'h0000, 1'b0);
    chk("unmapped", 16'h0000, got);
    for (int i = 0; i < 4; i++) begin
      bus(REG_ADDR, 16'(16'h0010 + i), 1'b1);
      bus(REG_WDATA, 16'(16'hA5A0 + i), 1'b1);
      mem_cmd(16'h0002);
    end
    // m[0] selects output timing, m[1] burst order; changed only while idle
    for (int m = 0; m < 4; m++) begin
      bus(REG_CTRL, {13'h0000, m[1], m[0], 1'b0}, 1'b1);
      chk("pins", {14'h0000, m[1], m[0]},
          {14'h0000, link.linear_order_select_n, link.flow_through_select_n});
      for (int s = 0; s < 4; s++) begin
        bus(REG_ADDR, 16'(16'h0010 + s), 1'b1);
        mem_rd(16'h0001, 16'(16'hA5A0 + s), "burst_load");
        for (int k = 1; k < 5; k++) begin
          e = m[1] ? (2'(s) ^ 2'(k)) : 2'(s + k);
          mem_rd(16'h0005, 16'hA5A0 + e, "burst_step");
        end
      end
    end
    bus(REG_CTRL, 16'h0007, 1'b1);
    repeat (8) @(posedge clk_i);
    #1 chk("asleep", 16'h0001, {15'h0000, asleep});
    chk("dq_released", 16'h0000, {15'h0000, link.dq_mem_oe});
    bus(REG_ADDR, 16'h0012, 1'b1);
    bus(REG_WDATA, 16'h5A5A, 1'b1);
    mem_cmd(16'h0002);
    chk("still_asleep", 16'h0001, {15'h0000, asleep});
    // a write tried inside the recovery interval must be refused
    bus(REG_CTRL, 16'h0006, 1'b1);
    mem_cmd(16'h0002);
    repeat (8) @(posedge clk_i);
    #1 chk("awake", 16'h0000, {15'h0000, asleep});
    mem_rd(16'h0001, 16'hA5A2, "retained");
    end_of_test();
  end
endmodule
